//--- hdl/qxrfe_dev.sv
// device end: quad i/o and continuous read transfer logic
`default_nettype none
module qxrfe_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] status_reg1_i,
  input wire logic [7:0] status_reg4_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_req_o,
  output logic [qxrfe_pkg::ADDR_W-1:0] rd_addr_o,
  output logic xip_active_o,
  output logic [2:0] wrap_sel_o,
  output logic busy_o,
  qxrfe_link_if.dev link
);
  import qxrfe_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DATA = 3'b101,
    ST_SKIP = 3'b110
  } qxrfe_dev_state_type;

  qxrfe_dev_state_type state;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic sck_q;
  logic cs_n;
  logic [3:0] io;
  logic sck_rise;
  logic sck_fall;
  logic [3:0] cnt;
  logic [7:0] cmd_sr;
  logic [7:0] op;
  logic [7:0] next_cmd;
  logic [7:0] mode_sr;
  logic [7:0] next_mode;
  logic [ADDR_W-1:0] addr;
  logic continuous_read_enable;
  logic [2:0] wrap;
  logic nib;
  logic id_sel;
  logic [3:0] lo;
  logic [7:0] out_byte;
  logic last_mode;
  logic aligned;

  // -------------------------------------------------------------
  // pin synchronisers and serial clock edges
  // -------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end
    else
    begin
      sync1 <= {link.cs_n, link.sck, link.io};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_q <= 1'b0;
    end
    else
    begin
      sck_q <= sync2[4];
    end
  end

  assign cs_n = sync2[5];
  assign io = sync2[3:0];
  assign sck_rise = sync2[4] & ~sck_q;
  assign sck_fall = ~sync2[4] & sck_q;
  assign next_cmd = {cmd_sr[6:0], io[0]};
  assign next_mode = {mode_sr[3:0], io};
  assign last_mode = (state == ST_MODE) && sck_rise && (cnt == MODE_CLKS - 4'h1);
  assign aligned = (op != OP_QREAD_ALIGNED) || ((addr[1:0] & ALIGN_MASK) == 2'b00);
  assign out_byte = (op == OP_QUAD_ID) ? (id_sel ? ID_DEV : ID_MFR) : rd_data_i;

  // -------------------------------------------------------------
  // frame sequencer
  // -------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_n)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          state <= continuous_read_enable ? ST_ADDR : ST_CMD;
          cnt <= 4'h0;
        end
        ST_CMD:
        begin
          if (sck_rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == CMD_CLKS - 4'h1)
            begin
              cnt <= 4'h0;
              // quad formats only when the quad flag is set
              if (op_is_quad(next_cmd) && status_reg1_i[QUAD_EN_POS])
              begin
                state <= ST_ADDR;
              end
              else
              begin
                state <= ST_SKIP;
              end
            end
          end
        end
        ST_ADDR:
        begin
          if (sck_rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == ADDR_CLKS - 4'h1)
            begin
              cnt <= 4'h0;
              state <= ST_MODE;
            end
          end
        end
        ST_MODE:
        begin
          if (sck_rise)
          begin
            cnt <= cnt + 4'h1;
          end
          if (last_mode)
          begin
            cnt <= 4'h0;
            // wrap setup ends here; misaligned aligned-read is dropped
            if (op == OP_SET_WRAP || !aligned)
            begin
              state <= ST_SKIP;
            end
            else
            begin
              state <= ST_DUMMY;
            end
          end
        end
        ST_DUMMY:
        begin
          if (sck_rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == DUMMY_CLKS - 4'h1)
            begin
              cnt <= 4'h0;
              state <= ST_DATA;
            end
          end
        end
        ST_DATA, ST_SKIP:
        begin
          state <= state;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // command, address and mode capture
  // -------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_sr <= 8'h00;
      op <= 8'h00;
    end
    else if (state == ST_CMD && sck_rise)
    begin
      cmd_sr <= next_cmd;
      if (cnt == CMD_CLKS - 4'h1)
      begin
        op <= next_cmd;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr <= '0;
      mode_sr <= 8'h00;
    end
    else if (state == ST_ADDR && sck_rise)
    begin
      addr <= {addr[ADDR_W-5:0], io};
    end
    else if (state == ST_MODE && sck_rise)
    begin
      mode_sr <= next_mode;
    end
    else if (state == ST_DATA && sck_fall && nib)
    begin
      addr <= wrap_next(addr, wrap);
    end
  end

  // continuous flag: decided by the mode byte, takes effect next frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      continuous_read_enable <= 1'b0;
    end
    else if (last_mode && op_is_xip(op))
    begin
      continuous_read_enable <= (next_mode[MODE_CONT_LO+1:MODE_CONT_LO] == MODE_CONT)
        && status_reg1_i[QUAD_EN_POS] && status_reg4_i[XIP_EN_POS];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wrap <= WRAP_RESET;
    end
    else if (last_mode && op == OP_SET_WRAP)
    begin
      wrap <= next_mode[WRAP_LO+2:WRAP_LO];
    end
  end

  // -------------------------------------------------------------
  // read data out, launched on falling edges
  // -------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_n)
    begin
      link.dev_oe <= OE_NONE;
      link.dev_io <= 4'h0;
      lo <= 4'h0;
      nib <= 1'b0;
      id_sel <= 1'b0;
    end
    else if (state == ST_DATA && sck_fall)
    begin
      link.dev_oe <= OE_ALL;
      nib <= ~nib;
      if (!nib)
      begin
        link.dev_io <= out_byte[7:4];
        lo <= out_byte[3:0];
      end
      else
      begin
        link.dev_io <= lo;
        id_sel <= ~id_sel;
      end
    end
  end

  // fetch request one byte ahead of the pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_req_o <= 1'b0;
    end
    else
    begin
      rd_req_o <= (op != OP_QUAD_ID) && ((last_mode && op != OP_SET_WRAP && aligned)
        || (state == ST_DATA && sck_fall && nib));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= (state != ST_IDLE);
    end
  end

  assign rd_addr_o = addr;
  assign xip_active_o = continuous_read_enable;
  assign wrap_sel_o = wrap;
endmodule
`default_nettype wire

//--- pkg/qxrfe_pkg.sv
// shared constants and helpers of the quad i/o xip read front end
// What this block does
// - command on line 0, then four lines
// - 24-bit address takes six quad clocks
// - write fields: host drives, device samples four
// - device drives four lines after dummy clocks
// - both ends count the same dummy clocks
// - quad identification read is supported
// - continuous read needs both enable flags at the device end; the host end sets cont_o from the mode bits alone
// - only two xip reads; second needs alignment
// - mode bits 5:4 at 10 enter continuous
// - continuous frames carry no command phase
// - chip select high stops device output
// - other mode value leaves continuous after frame
// - continuous mode executes only the xip reads
// - wrap command bits 6:4 select wrap section
// - host sets wrap only outside continuous
// - wrap command uses one-four-four format
// - sample on rising, launch on falling edge
`default_nettype none
package qxrfe_pkg;
  localparam int ADDR_W = 24;
  localparam logic [7:0] OP_QREAD = 8'hEB;
  localparam logic [7:0] OP_QREAD_ALIGNED = 8'hE7;
  localparam logic [7:0] OP_QUAD_ID = 8'h94;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [3:0] CMD_CLKS = 4'h8;
  localparam logic [3:0] ADDR_CLKS = 4'h6;
  localparam logic [3:0] MODE_CLKS = 4'h2;
  localparam logic [3:0] DUMMY_CLKS = 4'h4;
  localparam logic [1:0] MODE_CONT = 2'b10;
  localparam int MODE_CONT_LO = 4;
  localparam int WRAP_LO = 4;
  localparam int WRAP_OFF_BIT = 2;
  localparam logic [2:0] WRAP_RESET = 3'h7;
  localparam int QUAD_EN_POS = 2;
  localparam int XIP_EN_POS = 3;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  // identification values are arbitrary
  localparam logic [7:0] ID_MFR = 8'h5A;
  localparam logic [7:0] ID_DEV = 8'hC3;
  localparam logic [3:0] OE_LINE0 = 4'h1;
  localparam logic [3:0] OE_ALL = 4'hF;
  localparam logic [3:0] OE_NONE = 4'h0;
  // idle pin levels: deselected, clock low, lines pulled up; no false edge
  localparam logic [5:0] SYNC_RESET = 6'h2F;
  localparam int CLK_MHZ = 250;
  localparam int SCK_PERIOD_NS = 80;
  localparam logic [4:0] SCK_HALF_CLKS = 5'((SCK_PERIOD_NS * CLK_MHZ / 1000) / 2);
  localparam logic [4:0] CS_GAP_CLKS = 5'(SCK_PERIOD_NS * CLK_MHZ / 1000);

  function automatic logic op_is_xip(input logic [7:0] op);
    return (op == OP_QREAD) || (op == OP_QREAD_ALIGNED);
  endfunction

  function automatic logic op_is_quad(input logic [7:0] op);
    return op_is_xip(op) || (op == OP_QUAD_ID) || (op == OP_SET_WRAP);
  endfunction

  // wrap inside an 8/16/32/64 byte section, or plain increment
  function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic [2:0] sel);
    logic [23:0] mask;
    mask = (24'h00_0008 << sel[1:0]) - 24'h00_0001;
    if (sel[WRAP_OFF_BIT])
    begin
      return a + 24'h00_0001;
    end
    return (a & ~mask) | ((a + 24'h00_0001) & mask);
  endfunction
endpackage
`default_nettype wire

//--- pkg/qxrfe_link_if.sv
// link wires between the flash device end and the host end
`default_nettype none
interface qxrfe_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] host_io;
  logic [3:0] host_oe;
  logic [3:0] dev_io;
  logic [3:0] dev_oe;
  logic [3:0] io;
  // undriven lines read high, as with pull-ups
  assign io = (host_oe & host_io) | (~host_oe & dev_oe & dev_io) | (~host_oe & ~dev_oe);
  modport dev (input cs_n, input sck, input io, output dev_io, output dev_oe);
  modport host (output cs_n, output sck, output host_io, output host_oe, input io);
endinterface
`default_nettype wire

//--- hdl/qxrfe_host.sv
// host end: quad i/o and continuous read transfer controller
`default_nettype none
module qxrfe_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [qxrfe_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] mode_i,
  input wire logic [7:0] nbytes_i,
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic cont_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  qxrfe_link_if.host link
);
  import qxrfe_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CMD = 3'b001,
    H_ADDR = 3'b010,
    H_MODE = 3'b011,
    H_DUMMY = 3'b100,
    H_DATA = 3'b101,
    H_END = 3'b110,
    H_GAP = 3'b111
  } qxrfe_host_state_type;

  qxrfe_host_state_type state;
  logic [3:0] sync1;
  logic [3:0] io_s;
  logic [4:0] div;
  logic tick;
  logic [3:0] cnt;
  logic [7:0] cmd_sr;
  logic [31:0] q_sr;
  logic [7:0] last_op;
  logic [7:0] eff_op;
  logic is_wrap;
  logic refuse;
  logic [7:0] left;
  logic nib;
  logic [3:0] hi;
  logic [4:0] gap;

  assign eff_op = cont_o ? last_op : opcode_i;
  // wrap change only outside continuous; aligned read needs aligned address
  assign refuse = (cont_o && opcode_i == OP_SET_WRAP) || !op_is_quad(eff_op)
    || (eff_op == OP_QREAD_ALIGNED && (addr_i[1:0] & ALIGN_MASK) != 2'b00);
  assign tick = (div == SCK_HALF_CLKS - 5'h01);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 4'hF;
      io_s <= 4'hF;
    end
    else
    begin
      sync1 <= link.io;
      io_s <= sync1;
    end
  end

  // serial clock divider, runs in every state except idle, gap included
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state == H_IDLE || tick)
    begin
      div <= 5'h00;
    end
    else
    begin
      div <= div + 5'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= H_IDLE;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.host_io <= 4'h0;
      link.host_oe <= OE_NONE;
      cnt <= 4'h0;
      cmd_sr <= 8'h00;
      q_sr <= 32'h0000_0000;
      last_op <= 8'h00;
      is_wrap <= 1'b0;
      cont_o <= 1'b0;
      left <= 8'h00;
      nib <= 1'b0;
      hi <= 4'h0;
      gap <= 5'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      refused_o <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      refused_o <= 1'b0;
      rx_valid_o <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (start_i && refuse)
          begin
            refused_o <= 1'b1;
          end
          else if (start_i)
          begin
            busy_o <= 1'b1;
            link.cs_n <= 1'b0;
            cnt <= 4'h0;
            nib <= 1'b0;
            left <= nbytes_i;
            cmd_sr <= opcode_i;
            q_sr <= {addr_i, mode_i};
            is_wrap <= (eff_op == OP_SET_WRAP);
            if (!cont_o)
            begin
              last_op <= opcode_i;
            end
            if (op_is_xip(eff_op))
            begin
              cont_o <= (mode_i[MODE_CONT_LO+1:MODE_CONT_LO] == MODE_CONT);
            end
            if (cont_o)
            begin
              state <= H_ADDR;
              link.host_io <= addr_i[ADDR_W-1:ADDR_W-4];
              link.host_oe <= OE_ALL;
            end
            else
            begin
              state <= H_CMD;
              link.host_io <= {3'b000, opcode_i[7]};
              link.host_oe <= OE_LINE0;
            end
          end
        end
        H_GAP:
        begin
          // gap is longer than the 4-bit phase counter can hold
          gap <= gap + 5'h01;
          if (gap == CS_GAP_CLKS)
          begin
            state <= H_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        default:
        begin
          if (tick && !link.sck)
          begin
            // rising edge: the device samples, the host samples read data
            link.sck <= 1'b1;
            cnt <= cnt + 4'h1;
            if (state == H_CMD)
            begin
              cmd_sr <= {cmd_sr[6:0], 1'b0};
              if (cnt == CMD_CLKS - 4'h1)
              begin
                state <= H_ADDR;
                cnt <= 4'h0;
              end
            end
            if (state == H_ADDR || state == H_MODE)
            begin
              q_sr <= {q_sr[27:0], 4'h0};
            end
            if (state == H_ADDR && cnt == ADDR_CLKS - 4'h1)
            begin
              state <= H_MODE;
              cnt <= 4'h0;
            end
            if (state == H_MODE && cnt == MODE_CLKS - 4'h1)
            begin
              state <= is_wrap ? H_END : H_DUMMY;
              cnt <= 4'h0;
            end
            if (state == H_DUMMY && cnt == DUMMY_CLKS - 4'h1)
            begin
              state <= H_DATA;
            end
            if (state == H_DATA)
            begin
              nib <= ~nib;
              hi <= io_s;
              if (nib)
              begin
                rx_data_o <= {hi, io_s};
                rx_valid_o <= 1'b1;
                left <= left - 8'h01;
                if (left == 8'h01)
                begin
                  state <= H_END;
                end
              end
            end
          end
          else if (tick)
          begin
            // falling edge: launch the next host bits
            link.sck <= 1'b0;
            if (state == H_CMD)
            begin
              link.host_io <= {3'b000, cmd_sr[7]};
              link.host_oe <= OE_LINE0;
            end
            else if (state == H_ADDR || state == H_MODE)
            begin
              link.host_io <= q_sr[31:28];
              link.host_oe <= OE_ALL;
            end
            else
            begin
              link.host_oe <= OE_NONE;
            end
            if (state == H_END)
            begin
              link.cs_n <= 1'b1;
              state <= H_GAP;
              cnt <= 4'h0;
              gap <= 5'h00;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tb/qxrfe_link_sva.sv
// concurrent checks on the quad link between the device end and the host end
`default_nettype none
module qxrfe_link_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] host_io,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import qxrfe_pkg::*;
  logic sck_q;
  logic cmd_frame;
  logic cmd_now;
  logic rise;
  logic [9:0] rises;
  logic [9:0] ph;
  // ----------------------------------------
  // frame phase tracking
  // ----------------------------------------
  assign rise = sck && !sck_q;
  // frame kind is only known from the enables seen at the first rise
  assign cmd_now = (rises == 10'h000) ? (host_oe == OE_LINE0) : cmd_frame;
  // continuous frames start at the address phase
  assign ph = cmd_now ? rises : rises + 10'h008;
  always_ff @(posedge clk_i)
  begin
    sck_q <= rst_i ? 1'b0 : sck;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_n)
    begin
      rises <= 10'h000;
      cmd_frame <= 1'b1;
    end
    else if (rise)
    begin
      rises <= rises + 10'h001;
      cmd_frame <= cmd_now;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_cmd_on_line0: assert property (rise && ph < 10'h008 |-> host_oe == OE_LINE0)
    else $error("command bit not on line 0 alone");
  a_quad_fields: assert property (
    rise && ph >= 10'h008 && ph < 10'h010 |-> host_oe == OE_ALL)
    else $error("address or mode not on four lines");
  a_host_off_data: assert property (rise && ph >= 10'h010 |-> host_oe == OE_NONE)
    else $error("host still drives after mode byte");
  a_dev_silent_early: assert property (rise && ph < 10'h014 |-> dev_oe == OE_NONE)
    else $error("device drives before dummy clocks end");
  a_dev_drives_data: assert property (rise && ph >= 10'h014 |-> dev_oe == OE_ALL)
    else $error("device not driving four data lines");
  a_dev_release: assert property (cs_n [*8] |-> dev_oe == OE_NONE)
    else $error("device drives while deselected");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_launch_on_fall: assert property ($rose(sck) |=> $stable(host_io) [*8])
    else $error("host data changed in clock high phase");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("chip select gap too short");
  a_no_contention: assert property ((host_oe & dev_oe) == OE_NONE)
    else $error("both ends drive one line");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench joining the device end and the host end over the link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qxrfe_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i;
  logic start;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] mode;
  logic [7:0] nbytes;
  logic [7:0] status_reg1;
  logic [7:0] status_reg4;
  logic [7:0] rd_data = 8'h00;
  logic rd_req;
  logic [23:0] rd_addr;
  logic xip_active;
  logic [2:0] wrap_sel;
  logic dev_busy;
  logic host_busy;
  logic done;
  logic refused;
  logic cont;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] rxq[$];
  logic [23:0] aq[$];
  logic [2:0] cur_wrap;
  int bad_count = 0;
  int checks = 0;

  always #2 clk_i = ~clk_i;

  qxrfe_link_if u_link ();
  qxrfe_dev u_qxrfe_dev (.clk_i(clk_i), .rst_i(rst_i), .status_reg1_i(status_reg1),
    .status_reg4_i(status_reg4), .rd_data_i(rd_data), .rd_req_o(rd_req),
    .rd_addr_o(rd_addr), .xip_active_o(xip_active), .wrap_sel_o(wrap_sel),
    .busy_o(dev_busy), .link(u_link));
  qxrfe_host u_qxrfe_host (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .opcode_i(opcode),
    .addr_i(addr), .mode_i(mode), .nbytes_i(nbytes), .busy_o(host_busy), .done_o(done),
    .refused_o(refused), .cont_o(cont), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .link(u_link));
  qxrfe_link_sva u_qxrfe_link_sva (.clk_i(clk_i), .rst_i(rst_i), .cs_n(u_link.cs_n),
    .sck(u_link.sck), .host_io(u_link.host_io), .host_oe(u_link.host_oe),
    .dev_oe(u_link.dev_oe));

  // ----------------------------------------
  // memory stand-in and collectors
  // ----------------------------------------
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  function automatic logic [23:0] step(input logic [23:0] a, input logic [2:0] w);
    int span;
    span = 8 << w[1:0];
    if (w[2])
    begin
      return a + 24'h00_0001;
    end
    return a - 24'(a % span) + 24'((a + 1) % span);
  endfunction

  always @(posedge clk_i)
  begin
    if (rd_req === 1'b1)
    begin
      aq.push_back(rd_addr);
      rd_data <= mem_byte(rd_addr);
    end
    if (rx_valid === 1'b1)
    begin
      rxq.push_back(rx_data);
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    cur_wrap = WRAP_RESET;
    @(posedge clk_i);
  endtask

  // one transfer; data expectations follow the wrap setting the bench tracks
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
    input logic [7:0] n, input logic rf);
    int k;
    logic [23:0] ea;
    logic [1:0] seen;
    k = 0;
    seen = 2'b00;
    ea = a;
    rxq.delete();
    aq.delete();
    opcode <= op;
    addr <= a;
    mode <= m;
    nbytes <= n;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    do
    begin
      @(negedge clk_i);
      k++;
      seen = seen | {host_busy === 1'b1, dev_busy === 1'b1};
    end
    while (done !== 1'b1 && refused !== 1'b1 && k < 5000);
    chk(24'(k < 5000), 24'h00_0001);
    chk(24'(refused), 24'(rf));
    chk(24'(seen), rf ? 24'h00_0000 : 24'h00_0003);
    chk(24'({host_busy, dev_busy}), 24'h00_0000);
    if (!rf && op == OP_SET_WRAP)
      cur_wrap = m[6:4];
    else if (!rf)
    begin
      chk(24'(rxq.size()), 24'(n));
      for (int i = 0; i < n && i < rxq.size(); i++)
      begin
        if (op == OP_QUAD_ID)
          chk(24'(rxq[i]), 24'((i % 2) ? ID_DEV : ID_MFR));
        else
        begin
          chk(aq[i], ea);
          chk(24'(rxq[i]), 24'(mem_byte(ea)));
          ea = step(ea, cur_wrap);
        end
      end
    end
    @(posedge clk_i);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    start = 1'b0;
    opcode = 8'h00;
    addr = 24'h00_0000;
    mode = 8'h00;
    nbytes = 8'h01;
    status_reg1 = 8'h04;
    status_reg4 = 8'h08;
    do_reset();
    chk(24'(xip_active), 24'h00_0000);
    chk(24'(wrap_sel), 24'(WRAP_RESET));
    run(OP_QUAD_ID, 24'h00_0000, 8'h00, 8'h04, 1'b0);
    run(OP_QREAD_ALIGNED, 24'h00_0102, 8'h00, 8'h02, 1'b1);
    run(8'h03, 24'h00_0000, 8'h00, 8'h02, 1'b1);
    for (int s = 0; s < 5; s++)
    begin
      run(OP_SET_WRAP, 24'h00_0000, 8'(s << 4), 8'h01, 1'b0);
      chk(24'(wrap_sel), 24'(s));
      run(OP_QREAD, 24'h01_23FD, 8'h00, 8'h0C, 1'b0);
    end
    run(OP_QREAD_ALIGNED, 24'h00_0200, 8'h20, 8'h03, 1'b0);
    chk(24'(xip_active), 24'h00_0001);
    run(OP_QREAD, 24'h00_0310, 8'h20, 8'h03, 1'b0);
    chk(24'(xip_active), 24'h00_0001);
    run(OP_SET_WRAP, 24'h00_0000, 8'h00, 8'h01, 1'b1);
    run(OP_QREAD, 24'h00_0420, 8'h00, 8'h03, 1'b0);
    chk(24'(xip_active), 24'h00_0000);
    chk(24'(cont), 24'h00_0000);
    run(OP_QREAD, 24'h00_0501, 8'h00, 8'h02, 1'b0);
    status_reg4 <= 8'h00;
    run(OP_QREAD, 24'h00_0600, 8'h20, 8'h02, 1'b0);
    chk(24'(xip_active), 24'h00_0000);
    do_reset();
    chk(24'(cont), 24'h00_0000);
    chk(24'(wrap_sel), 24'(WRAP_RESET));
    status_reg4 <= 8'h08;
    run(OP_QUAD_ID, 24'h00_0000, 8'h00, 8'h02, 1'b0);
    conclude();
  end

  initial
  begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
